// [design/b_channel_unit.sv]
// One channel: pin filter, capture trigger select and compare pin level
`timescale 1ns/1ps
`default_nettype none
module b_channel_unit
    import timer_b_pkg::*;
#(
    parameter int CHAN = 1
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire timer_b_pkg::b_ctl_type ctl,
    input wire logic ctl_wr,
    input wire logic cnt_equal,
    input wire logic pin_in,
    input wire logic ch0c_event,
    input wire logic ch4_tick,
    input wire logic [2:0] ch4_psc,
    output timer_b_pkg::b_evt_type evt,
    output logic pin_out,
    output logic pin_oe
);
    logic [2:0] sync_ff, nxt_sync;
    logic level_ff, nxt_level;
    logic eq_prev_ff, nxt_eq_prev;
    logic out_ff, nxt_out;
    logic oe_ff, nxt_oe;
    logic rise, fall, pin_edge;
    cap_src_type src;

    // Pin filter: a change counts once the second and third stages agree
    always_comb begin
        nxt_sync = {sync_ff[1:0], pin_in};
        nxt_level = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : level_ff;
        rise = (sync_ff[1] == sync_ff[2]) && sync_ff[2] && !level_ff;
        fall = (sync_ff[1] == sync_ff[2]) && !sync_ff[2] && level_ff;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sync_ff <= 3'h0;
            level_ff <= 1'b0;
        end else begin
            sync_ff <= nxt_sync;
            level_ff <= nxt_level;
        end
    end

    always_comb begin
        src = cap_source(CHAN, ctl);
        // Both edges when bit 5 set, else bit 4 picks falling over rising
        if (ctl.pair[1]) begin
            pin_edge = rise || fall;
        end else if (ctl.pair[0]) begin
            pin_edge = fall;
        end else begin
            pin_edge = rise;
        end
        case (src)
            SRC_PIN: evt.capture = pin_edge;
            SRC_CH0C: evt.capture = ch0c_event;
            SRC_CH4CLK: evt.capture = ch4_tick && (ch4_psc != PSC_UNDIVIDED);
            default: evt.capture = 1'b0;
        endcase
        evt.match = !ctl.cap_mode && cnt_equal && !eq_prev_ff;
    end

    // Compare pin level
    always_comb begin
        nxt_eq_prev = cnt_equal;
        nxt_out = out_ff;
        nxt_oe = !ctl.cap_mode && (ctl.pair != PAIR_OFF);
        if (ctl_wr && nxt_oe) begin
            nxt_out = ctl.init_high;
        end else if (evt.match) begin
            case (ctl.pair)
                PAIR_LOW: nxt_out = 1'b0;
                PAIR_HIGH: nxt_out = 1'b1;
                PAIR_TOGGLE: nxt_out = !out_ff;
                default: nxt_out = out_ff;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            eq_prev_ff <= 1'b0;
            out_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else begin
            eq_prev_ff <= nxt_eq_prev;
            out_ff <= nxt_out;
            oe_ff <= nxt_oe;
        end
    end

    assign pin_out = out_ff;
    assign pin_oe = oe_ff;

endmodule
`default_nettype wire

// [design/timer_b_pin_io_control.sv]
// Top: B register pin control for channels 1 to 3, registers and interrupt
//
// Operation
// - Bit 7 clear selects compare; bit 6 clear, nonzero pair: pin starts low.
// - Compare mode, bit 6 set, nonzero pair: pin starts high before any match.
// - Compare pair 00 disables the pin; pair 01 drives low on match.
// - Compare pair 10 drives the pin high on match.
// - Compare pair 11 toggles the pin on each match.
// - Pin capture with pair 00 captures on rising pin edge.
// - Pin capture with pair 01 captures on falling pin edge.
// - Pin capture with bit 5 set captures on both edges.
// - Channel 1 codes 1000 to 1011 capture from its own pin.
// - Channel 1 code 11xx captures on channel 0 C register event.
// - Channel 2 ignores bit 6 in capture; always its own pin.
// - Channel 3 codes 10xx capture from its own pin.
// - Channel 3 code 11xx captures on each channel 4 count tick.
// - No channel 4 tick capture while its prescaler field is 000.
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module timer_b_pin_io_control
    import timer_b_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [timer_b_pkg::ADDR_W-1:0] addr,
    input wire logic [timer_b_pkg::DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [timer_b_pkg::DATA_W-1:0] rdata,
    input wire logic [timer_b_pkg::CNT_W-1:0] ch1_counter,
    input wire logic [timer_b_pkg::CNT_W-1:0] ch2_counter,
    input wire logic [timer_b_pkg::CNT_W-1:0] ch3_counter,
    input wire logic ch0_c_event,
    input wire logic ch4_count_tick,
    input wire logic [2:0] ch4_prescale_sel,
    input wire logic ch1_b_pin_in,
    input wire logic ch2_b_pin_in,
    input wire logic ch3_b_pin_in,
    output logic ch1_b_pin_out,
    output logic ch2_b_pin_out,
    output logic ch3_b_pin_out,
    output logic ch1_b_pin_oe,
    output logic ch2_b_pin_oe,
    output logic ch3_b_pin_oe,
    output logic irq
);
    import timer_b_pkg::*;

    localparam logic [ADDR_W-1:0] OFF_CTL [NUM_CH] = '{OFF_CH1_CTL, OFF_CH2_CTL, OFF_CH3_CTL};
    localparam logic [ADDR_W-1:0] OFF_GREG [NUM_CH] = '{OFF_CH1_GREG, OFF_CH2_GREG, OFF_CH3_GREG};

    // Control field registers and B general registers
    logic [7:0] ctl_ff [NUM_CH];
    logic [7:0] nxt_ctl [NUM_CH];
    logic [CNT_W-1:0] greg_ff [NUM_CH];
    logic [CNT_W-1:0] nxt_greg [NUM_CH];
    logic ctl_wr [NUM_CH];

    // Interrupt group
    logic [STAT_W-1:0] status_ff, nxt_status;
    logic [STAT_W-1:0] enable_ff, nxt_enable;
    logic irq_ff, nxt_irq;
    logic [STAT_W-1:0] event_set;
    logic [STAT_W-1:0] clear_mask;

    // Read port
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;

    // Per channel wiring
    logic [CNT_W-1:0] counter [NUM_CH];
    logic pin_in [NUM_CH];
    logic pin_out [NUM_CH];
    logic pin_oe [NUM_CH];
    logic cnt_equal [NUM_CH];
    b_evt_type evt [NUM_CH];
    b_ctl_type ctl_dec [NUM_CH];

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return a == off;
    endfunction

    assign counter[0] = ch1_counter;
    assign counter[1] = ch2_counter;
    assign counter[2] = ch3_counter;
    assign pin_in[0] = ch1_b_pin_in;
    assign pin_in[1] = ch2_b_pin_in;
    assign pin_in[2] = ch3_b_pin_in;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gen_ch
            // Software write of the control byte
            always_comb begin
                ctl_wr[g] = wr_stb && hit(addr, OFF_CTL[g]);
                nxt_ctl[g] = ctl_wr[g] ? wdata[7:0] : ctl_ff[g];
            end

            assign ctl_dec[g] = decode_ctl(ctl_ff[g]);
            assign cnt_equal[g] = counter[g] == greg_ff[g];

            // Capture overrides a software write in the same cycle
            always_comb begin
                nxt_greg[g] = greg_ff[g];
                if (wr_stb && hit(addr, OFF_GREG[g])) begin
                    nxt_greg[g] = wdata[CNT_W-1:0];
                end
                if (evt[g].capture) begin
                    nxt_greg[g] = counter[g];
                end
            end

            always_ff @(posedge core_clk) begin
                if (!rstn) begin
                    ctl_ff[g] <= CTL_RESET;
                    greg_ff[g] <= GREG_RESET;
                end else begin
                    ctl_ff[g] <= nxt_ctl[g];
                    greg_ff[g] <= nxt_greg[g];
                end
            end

            // The unit sees the byte being written so the level lands with it
            b_channel_unit #(
                .CHAN(g + 1)
            ) u_unit (
                .core_clk(core_clk),
                .rstn(rstn),
                .ctl(ctl_wr[g] ? decode_ctl(wdata[7:0]) : ctl_dec[g]),
                .ctl_wr(ctl_wr[g]),
                .cnt_equal(cnt_equal[g]),
                .pin_in(pin_in[g]),
                .ch0c_event(ch0_c_event),
                .ch4_tick(ch4_count_tick),
                .ch4_psc(ch4_prescale_sel),
                .evt(evt[g]),
                .pin_out(pin_out[g]),
                .pin_oe(pin_oe[g])
            );

            assign event_set[STAT_CAP_LSB + g] = evt[g].capture;
            assign event_set[STAT_MATCH_LSB + g] = evt[g].match;
        end
    endgenerate

    // Sticky status: a new event wins over a clear in the same cycle
    always_comb begin
        clear_mask = '0;
        if (wr_stb && hit(addr, OFF_CLEAR)) begin
            clear_mask = wdata[STAT_W-1:0];
        end
        nxt_status = (status_ff & ~clear_mask) | event_set;
        nxt_enable = enable_ff;
        if (wr_stb && hit(addr, OFF_ENABLE)) begin
            nxt_enable = wdata[STAT_W-1:0];
        end
        nxt_irq = |(nxt_status & nxt_enable);
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            status_ff <= EVT_RESET;
            enable_ff <= EVT_RESET;
            irq_ff <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            enable_ff <= nxt_enable;
            irq_ff <= nxt_irq;
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_comb begin
        nxt_rdata = RDATA_RESET;
        if (rd_stb) begin
            case (addr)
                OFF_CH1_CTL: nxt_rdata = {8'h00, ctl_ff[0]};
                OFF_CH2_CTL: nxt_rdata = {8'h00, ctl_ff[1]};
                OFF_CH3_CTL: nxt_rdata = {8'h00, ctl_ff[2]};
                OFF_CH1_GREG: nxt_rdata = greg_ff[0];
                OFF_CH2_GREG: nxt_rdata = greg_ff[1];
                OFF_CH3_GREG: nxt_rdata = greg_ff[2];
                OFF_STATUS: nxt_rdata = {10'h000, status_ff};
                OFF_ENABLE: nxt_rdata = {10'h000, enable_ff};
                OFF_PINS: nxt_rdata = {10'h000, pin_oe[2], pin_oe[1], pin_oe[0],
                    pin_out[2], pin_out[1], pin_out[0]};
                default: nxt_rdata = RDATA_RESET;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rdata_ff <= RDATA_RESET;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata = rdata_ff;
    assign irq = irq_ff;
    assign ch1_b_pin_out = pin_out[0];
    assign ch2_b_pin_out = pin_out[1];
    assign ch3_b_pin_out = pin_out[2];
    assign ch1_b_pin_oe = pin_oe[0];
    assign ch2_b_pin_oe = pin_oe[1];
    assign ch3_b_pin_oe = pin_oe[2];

endmodule
`default_nettype wire

// [design/timer_b_pkg.sv]
// Constants, types and decode functions for the timer B register pin control
package timer_b_pkg;

    localparam int NUM_CH = 3;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;

    // Register byte offsets
    localparam logic [5:0] OFF_CH1_CTL = 6'h00;
    localparam logic [5:0] OFF_CH2_CTL = 6'h04;
    localparam logic [5:0] OFF_CH3_CTL = 6'h08;
    localparam logic [5:0] OFF_CH1_GREG = 6'h0c;
    localparam logic [5:0] OFF_CH2_GREG = 6'h10;
    localparam logic [5:0] OFF_CH3_GREG = 6'h14;
    localparam logic [5:0] OFF_STATUS = 6'h18;
    localparam logic [5:0] OFF_ENABLE = 6'h1c;
    localparam logic [5:0] OFF_CLEAR = 6'h20;
    localparam logic [5:0] OFF_PINS = 6'h24;

    // Values after reset
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [15:0] GREG_RESET = 16'hffff;
    localparam logic [5:0] EVT_RESET = 6'h00;
    localparam logic [15:0] RDATA_RESET = 16'h0000;

    // Control field positions
    localparam int CTL_MODE_BIT = 7;
    localparam int CTL_INIT_BIT = 6;
    localparam int CTL_PAIR_MSB = 5;
    localparam int CTL_PAIR_LSB = 4;

    // Status layout: capture events low, compare events above
    localparam int STAT_CAP_LSB = 0;
    localparam int STAT_MATCH_LSB = 3;
    localparam int STAT_W = 6;

    // Low pair codes
    localparam logic [1:0] PAIR_OFF = 2'h0;
    localparam logic [1:0] PAIR_LOW = 2'h1;
    localparam logic [1:0] PAIR_HIGH = 2'h2;
    localparam logic [1:0] PAIR_TOGGLE = 2'h3;

    // Channel 4 prescaler code meaning the undivided peripheral clock
    localparam logic [2:0] PSC_UNDIVIDED = 3'h0;

    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_PIN,
        SRC_CH0C,
        SRC_CH4CLK
    } cap_src_type;

    typedef struct packed {
        logic cap_mode;
        logic init_high;
        logic [1:0] pair;
    } b_ctl_type;

    typedef struct packed {
        logic capture;
        logic match;
    } b_evt_type;

    function automatic b_ctl_type decode_ctl(input logic [7:0] b);
        b_ctl_type c;
        c.cap_mode = b[CTL_MODE_BIT];
        c.init_high = b[CTL_INIT_BIT];
        c.pair = b[CTL_PAIR_MSB:CTL_PAIR_LSB];
        return c;
    endfunction

    function automatic cap_src_type cap_source(input int chan, input b_ctl_type c);
        cap_src_type s;
        s = SRC_NONE;
        if (c.cap_mode) begin
            s = SRC_PIN;
            if (c.init_high && chan == 1) begin
                s = SRC_CH0C;
            end else if (c.init_high && chan == 3) begin
                s = SRC_CH4CLK;
            end
        end
        return s;
    endfunction

endpackage

// [sim/far_side.sv]
// Far side model: external pin drivers and neighbour channel events
`timescale 1ns/1ps
`default_nettype none
module far_side (
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    input wire logic [2:0] ext_lvl,
    input wire logic [1:0] ev_req,
    output logic [2:0] pin_in,
    output logic c0_evt,
    output logic tick
);
    // Device drive wins on the wire while enabled
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
    assign c0_evt = ev_req[0];
    assign tick = ev_req[1];
endmodule
`default_nettype wire

// [sim/timer_b_pin_io_control_tb.sv]
// Self-checking bench for the B register pin control block
`timescale 1ns/1ps
`default_nettype none
module timer_b_pin_io_control_tb;
    import timer_b_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [2:0][CNT_W-1:0] cnt = '0;
    logic [2:0] ext = '0;
    logic [1:0] ev_req = '0;
    logic [2:0] psc = 3'h0;
    logic [2:0] pout, poe, pin;
    logic c0, tick, irq;
    logic [15:0] d;
    logic [15:0] want;
    int bad_count = 0;
    int compares = 0;
    // Code, then {oe, level} at start, after first and second match
    logic [13:0] rows [8] = '{14'h0000, 14'h042a, 14'h082f, 14'h0c2e,
        14'h1000, 14'h143a, 14'h183f, 14'h1c3b};

    timer_b_pin_io_control dut (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .ch1_counter(cnt[0]),
        .ch2_counter(cnt[1]), .ch3_counter(cnt[2]), .ch0_c_event(c0), .ch4_count_tick(tick),
        .ch4_prescale_sel(psc), .ch1_b_pin_in(pin[0]), .ch2_b_pin_in(pin[1]),
        .ch3_b_pin_in(pin[2]), .ch1_b_pin_out(pout[0]), .ch2_b_pin_out(pout[1]),
        .ch3_b_pin_out(pout[2]), .ch1_b_pin_oe(poe[0]), .ch2_b_pin_oe(poe[1]),
        .ch3_b_pin_oe(poe[2]), .irq(irq));
    far_side far (.pin_out(pout), .pin_oe(poe), .ext_lvl(ext), .ev_req(ev_req),
        .pin_in(pin), .c0_evt(c0), .tick(tick));

    always #10 core_clk = ~core_clk;

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge core_clk);
        addr <= a;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge core_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic cap(input int c, input logic l, input logic [15:0] v, input logic [15:0] e);
        @(posedge core_clk);
        cnt[c] <= v;
        ext[c] <= l;
        repeat (8) @(posedge core_clk);
        rd(OFF_CH1_GREG + 6'(4 * c));
        chk(d, e);
    endtask

    task automatic ev(input int c, input logic [1:0] m, input logic [15:0] e);
        @(posedge core_clk);
        ev_req <= m;
        @(posedge core_clk);
        ev_req <= 2'h0;
        repeat (3) @(posedge core_clk);
        rd(OFF_CH1_GREG + 6'(4 * c));
        chk(d, e);
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        bad_count++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        rd(OFF_CH1_CTL);
        chk(d, 16'h0000);
        rd(OFF_CH1_GREG);
        chk(d, 16'hffff);
        rd(6'h3c);
        chk(d, 16'h0000);
        for (int c = 0; c < 3; c++) begin
            for (int i = 0; i < 8; i++) begin
                wr(OFF_CH1_CTL + 6'(4 * c), 16'(rows[i][13:6]));
                wr(OFF_CH1_GREG + 6'(4 * c), 16'h0010);
                for (int k = 0; k < 3; k++) begin
                    if (k > 0) begin
                        @(posedge core_clk);
                        cnt[c] <= 16'h0010;
                        @(posedge core_clk);
                        cnt[c] <= '0;
                        repeat (2) @(posedge core_clk);
                    end
                    want = 16'(rows[i][5 - 2 * k -: 2]);
                    rd(OFF_PINS);
                    chk(16'({d[3 + c], d[3 + c] & d[c]}), want);
                    chk(16'({poe[c], poe[c] & pout[c]}), want);
                end
            end
            wr(OFF_CH1_CTL + 6'(4 * c), 16'h0000);
        end
        rd(OFF_STATUS);
        chk(d, 16'h0038);
        wr(OFF_CLEAR, 16'h003f);
        wr(OFF_ENABLE, 16'h0001);
        wr(OFF_CH1_CTL, 16'h0080);
        cap(0, 1'b1, 16'h1234, 16'h1234);
        chk(16'(irq), 16'h0001);
        cap(0, 1'b0, 16'h2222, 16'h1234);
        wr(OFF_ENABLE, 16'h0000);
        chk(16'(irq), 16'h0000);
        wr(OFF_CLEAR, 16'h003f);
        wr(OFF_ENABLE, 16'h0001);
        chk(16'(irq), 16'h0000);
        wr(OFF_CH2_CTL, 16'h00d0);
        cap(1, 1'b1, 16'h0aaa, 16'h0010);
        cap(1, 1'b0, 16'h0bbb, 16'h0bbb);
        wr(OFF_CH3_CTL, 16'h00a0);
        cap(2, 1'b1, 16'h0ccc, 16'h0ccc);
        cap(2, 1'b0, 16'h0ddd, 16'h0ddd);
        wr(OFF_CH1_CTL, 16'h00c0);
        cap(0, 1'b1, 16'h0eee, 16'h1234);
        ev(0, 2'h1, 16'h0eee);
        wr(OFF_CH3_CTL, 16'h00f0);
        @(posedge core_clk);
        cnt[2] <= 16'h0fff;
        ev(2, 2'h2, 16'h0ddd);
        @(posedge core_clk);
        psc <= 3'h1;
        ev(2, 2'h2, 16'h0fff);
        // Reset in mid-run restores register reset values and clears pins and the interrupt
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        rd(OFF_CH3_CTL);
        chk(d, 16'h0000);
        rd(OFF_CH3_GREG);
        chk(d, 16'hffff);
        rd(OFF_STATUS);
        chk(d, 16'h0000);
        chk(16'({poe, pout, irq}), 16'h0000);
        report_and_stop();
    end
endmodule
`default_nettype wire

// [sim/timer_b_props.sv]
// Port checker for the B register pin control block
`timescale 1ns/1ps
`default_nettype none
module b_props
    import timer_b_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [timer_b_pkg::ADDR_W-1:0] addr,
    input wire logic [timer_b_pkg::DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [timer_b_pkg::DATA_W-1:0] rdata,
    input wire logic [timer_b_pkg::CNT_W-1:0] ch1_counter,
    input wire logic ch1_b_pin_out,
    input wire logic ch2_b_pin_out,
    input wire logic ch3_b_pin_out,
    input wire logic ch1_b_pin_oe,
    input wire logic ch2_b_pin_oe,
    input wire logic ch3_b_pin_oe,
    input wire logic irq
);
    import timer_b_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    rd_quiet_a:
    assert property (rdata != 16'h0000 |-> $past(rd_stb)) else $error("rdata without read");
    init_level_a:
    assert property (wr_stb && addr == OFF_CH1_CTL && !wdata[7] && wdata[5:4] != 2'h0
        |=> ch1_b_pin_oe && ch1_b_pin_out == $past(wdata[6])) else $error("ch1 start level");
    init_ch3_a:
    assert property (wr_stb && addr == OFF_CH3_CTL && !wdata[7] && wdata[5:4] != 2'h0
        |=> ch3_b_pin_oe && ch3_b_pin_out == $past(wdata[6])) else $error("ch3 start level");
    off_oe_a:
    assert property (wr_stb && addr == OFF_CH2_CTL && (wdata[7] || wdata[5:4] == 2'h0)
        |-> ##2 !ch2_b_pin_oe) else $error("ch2 drive not off");
    off_hold_a:
    assert property ($changed(ch2_b_pin_out) |-> $past(wr_stb) || ch2_b_pin_oe)
        else $error("ch2 pin moved while off");
    pin_hold_a:
    assert property ($changed(ch1_b_pin_out) |-> $past(wr_stb) || $past(wr_stb, 2)
        || $past(ch1_counter) != $past(ch1_counter, 2)) else $error("ch1 pin moved alone");
    oe_write_a:
    assert property ($changed(ch3_b_pin_oe) |-> $past(wr_stb) || $past(wr_stb, 2))
        else $error("ch3 drive moved alone");
    pin_view_a:
    assert property (rd_stb && addr == OFF_PINS |=> rdata[5:0] == $past({ch3_b_pin_oe,
        ch2_b_pin_oe, ch1_b_pin_oe, ch3_b_pin_out, ch2_b_pin_out, ch1_b_pin_out}))
        else $error("pin view wrong");
    cover property ($rose(irq));
    cover property ($changed(ch1_b_pin_out) && !$past(wr_stb));
    cover property ($rose(ch2_b_pin_oe));
endmodule
bind timer_b_pin_io_control b_props chk_i (.core_clk(core_clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq),
    .ch1_counter(ch1_counter), .ch1_b_pin_out(ch1_b_pin_out), .ch2_b_pin_out(ch2_b_pin_out),
    .ch3_b_pin_out(ch3_b_pin_out), .ch1_b_pin_oe(ch1_b_pin_oe), .ch2_b_pin_oe(ch2_b_pin_oe),
    .ch3_b_pin_oe(ch3_b_pin_oe));
`default_nettype wire
